// *** core/sbr_top.sv ***
// Purpose: Bit rate generator of the enhanced serial port with Avalon-MM registers.
// Assumes: CLK is the device clock; CK_I and RXD are asynchronous pins.
// Notes: Framing, auto-baud and wake-up are outside this block.
//
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
module sbr_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic [sbr_pkg::ADDR_W-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic RXD,
    input wire logic CK_I,
    output logic CK_O,
    output logic CK_OE,
    output logic BIT_TICK,
    output logic RX_BIT,
    output logic RX_BIT_VALID
);
    import sbr_pkg::*;

    // ----------------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------------
    logic [7:0] tx_ctl_q;
    logic [7:0] rx_ctl_q;
    logic [7:0] baud_ctl_q;
    logic [7:0] div_high_q;
    logic [7:0] div_low_q;
    logic div_clr_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic bus_req;
    logic bus_ack;
    logic wr_en;
    logic [7:0] wbyte;
    logic [7:0] rbyte;
    logic port_en;
    logic sync_mode;
    logic clk_src;
    logic high_speed;
    logic wide_div;
    sbr_mode_t mode;
    logic [15:0] period;
    logic rate_tick;
    logic [5:0] factor_m1;
    logic [5:0] half;
    logic [5:0] sub_q;
    logic sub_wrap;
    logic ck_meta_q;
    logic ck_sync_q;
    logic ck_prev_q;
    logic ck_rise;
    logic [1:0] slv_cnt_q;
    logic samp;
    logic last;
    logic bit_tick_q;
    logic ck_q;
    logic ck_oe_q;
    logic vote_bit;
    logic vote_valid;
    logic rx_bit_q;
    logic rx_valid_q;

    // ----------------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------------
    // Every access is answered with exactly one wait cycle; the read data is
    // captured in the same edge that drops waitrequest, so it is stable when
    // the master samples it.
    assign bus_req = AVS_READ | AVS_WRITE;
    assign bus_ack = bus_req & ~wait_q;
    assign wr_en = AVS_WRITE & ~wait_q & AVS_BYTEENABLE[0];
    assign wbyte = AVS_WRITEDATA[7:0];

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wait_q <= 1'b1;
        end else if (CE) begin
            wait_q <= ~(bus_req & wait_q);
        end
    end

    always_comb begin
        rbyte = BYTE_ZERO;
        unique case (AVS_ADDRESS)
            OFS_TX_CTL: begin
                rbyte = tx_ctl_q;
            end
            OFS_RX_CTL: begin
                rbyte = rx_ctl_q;
            end
            OFS_BAUD_CTL: begin
                rbyte = baud_ctl_q;
            end
            OFS_DIV_HIGH: begin
                rbyte = div_high_q;
            end
            OFS_DIV_LOW: begin
                rbyte = div_low_q;
            end
            OFS_STATUS: begin
                rbyte = {5'h00, ck_oe_q, ck_q, rx_bit_q};
            end
            default: begin
                rbyte = BYTE_ZERO;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_q <= 32'h00000000;
        end else if (CE) begin
            if (AVS_READ && wait_q) begin
                rdata_q <= {24'h000000, rbyte};
            end
        end
    end

    // ----------------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------------
    // Bits with no function in this block are stored so software sees what it
    // wrote; read-only status bits show their idle values.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_ctl_q <= TX_CTL_RST;
        end else if (CE) begin
            if (wr_en && AVS_ADDRESS == OFS_TX_CTL) begin
                tx_ctl_q <= (wbyte & TX_CTL_WMASK) | (TX_CTL_RST & ~TX_CTL_WMASK);
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_ctl_q <= BYTE_ZERO;
        end else if (CE) begin
            if (wr_en && AVS_ADDRESS == OFS_RX_CTL) begin
                rx_ctl_q <= wbyte & RX_CTL_WMASK;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            baud_ctl_q <= BYTE_ZERO;
            baud_ctl_q[BAUD_RX_IDLE_BIT] <= 1'b1;
        end else if (CE) begin
            if (wr_en && AVS_ADDRESS == OFS_BAUD_CTL) begin
                baud_ctl_q <= wbyte & BAUD_CTL_WMASK;
                baud_ctl_q[BAUD_RX_IDLE_BIT] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Divisor registers
    // ----------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            div_high_q <= BYTE_ZERO;
            div_low_q <= BYTE_ZERO;
            div_clr_q <= 1'b0;
        end else if (CE) begin
            div_clr_q <= 1'b0;
            if (wr_en && AVS_ADDRESS == OFS_DIV_HIGH) begin
                div_high_q <= wbyte;
                div_clr_q <= 1'b1;
            end
            if (wr_en && AVS_ADDRESS == OFS_DIV_LOW) begin
                div_low_q <= wbyte;
                div_clr_q <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------------
    assign port_en = rx_ctl_q[RX_PORT_EN_BIT];
    assign sync_mode = tx_ctl_q[TX_SYNC_BIT];
    assign clk_src = tx_ctl_q[TX_CLK_SRC_BIT];
    assign high_speed = tx_ctl_q[TX_HIGH_SPEED_BIT];
    assign wide_div = baud_ctl_q[BAUD_WIDTH_BIT];

    always_comb begin
        if (!sync_mode) begin
            mode = SBR_ASYNC;
        end else if (clk_src) begin
            mode = SBR_MASTER;
        end else begin
            mode = SBR_SLAVE;
        end
    end

    // The high byte is masked off rather than ignored in the timer so that a
    // stale high value can never lengthen an 8-bit period.
    assign period = wide_div ? {div_high_q, div_low_q} : {BYTE_ZERO, div_low_q};

    always_comb begin
        factor_m1 = FACTOR4_M1;
        unique case ({sync_mode, wide_div, high_speed})
            3'b000: begin
                factor_m1 = FACTOR64_M1;
            end
            3'b001: begin
                factor_m1 = FACTOR16_M1;
            end
            3'b010: begin
                factor_m1 = FACTOR16_M1;
            end
            3'b011: begin
                factor_m1 = FACTOR4_M1;
            end
            default: begin
                factor_m1 = FACTOR4_M1;
            end
        endcase
    end

    assign half = {1'b0, factor_m1[5:1]} + 6'h01;

    // ----------------------------------------------------------------------
    // Rate timer and post divider
    // ----------------------------------------------------------------------
    sbr_timer u_timer (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .clr(div_clr_q),
        .run(port_en),
        .period(period),
        .tick(rate_tick)
    );

    assign sub_wrap = rate_tick & (sub_q >= factor_m1);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sub_q <= 6'h00;
        end else if (CE) begin
            if (div_clr_q || !port_en) begin
                sub_q <= 6'h00;
            end else if (sub_wrap) begin
                sub_q <= 6'h00;
            end else if (rate_tick) begin
                sub_q <= sub_q + 6'h01;
            end
        end
    end

    // ----------------------------------------------------------------------
    // External serial clock
    // ----------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ck_meta_q <= 1'b0;
            ck_sync_q <= 1'b0;
            ck_prev_q <= 1'b0;
        end else if (CE) begin
            ck_meta_q <= CK_I;
            ck_sync_q <= ck_meta_q;
            ck_prev_q <= ck_sync_q;
        end
    end

    assign ck_rise = ck_sync_q & ~ck_prev_q;

    // A slave has no internal bit timing, so its three samples are taken on
    // the three cycles after the clock edge; this limits the slave clock to
    // well below a quarter of CLK.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            slv_cnt_q <= 2'b00;
        end else if (CE) begin
            if (mode == SBR_SLAVE && port_en && ck_rise) begin
                slv_cnt_q <= 2'b11;
            end else if (slv_cnt_q != 2'b00) begin
                slv_cnt_q <= slv_cnt_q - 2'b01;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Sample strobes
    // ----------------------------------------------------------------------
    always_comb begin
        samp = 1'b0;
        last = 1'b0;
        if (mode == SBR_SLAVE) begin
            samp = slv_cnt_q != 2'b00;
            last = slv_cnt_q == 2'b01;
        end else if (rate_tick && port_en) begin
            samp = (sub_q == half - 6'h01) || (sub_q == half) || (sub_q == half + 6'h01);
            last = sub_q == half + 6'h01;
        end
    end

    sbr_vote u_vote (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .pin(RXD),
        .samp(samp),
        .last(last),
        .bit_out(vote_bit),
        .bit_valid(vote_valid)
    );

    // ----------------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bit_tick_q <= 1'b0;
        end else if (CE) begin
            if (mode == SBR_SLAVE) begin
                bit_tick_q <= port_en & ck_rise;
            end else begin
                bit_tick_q <= sub_wrap & port_en;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ck_q <= 1'b0;
            ck_oe_q <= 1'b0;
        end else if (CE) begin
            ck_oe_q <= (mode == SBR_MASTER) && port_en;
            if (mode == SBR_MASTER && port_en) begin
                ck_q <= sub_q >= half;
            end else begin
                ck_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rx_bit_q <= 1'b1;
            rx_valid_q <= 1'b0;
        end else if (CE) begin
            rx_valid_q <= vote_valid;
            if (vote_valid) begin
                rx_bit_q <= vote_bit;
            end
        end
    end

    assign AVS_READDATA = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign CK_O = ck_q;
    assign CK_OE = ck_oe_q;
    assign BIT_TICK = bit_tick_q;
    assign RX_BIT = rx_bit_q;
    assign RX_BIT_VALID = rx_valid_q;

endmodule

// *** inc/sbr_pkg.sv ***
// Purpose: Shared constants for the serial bit rate generator.
// Assumes: Registers are byte wide and sit in the low byte of each 32-bit word.
// Notes: Divide factors are stored minus one so they compare directly with counts.
package sbr_pkg;

    // ----------------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] OFS_TX_CTL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_RX_CTL = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_BAUD_CTL = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_DIV_HIGH = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_DIV_LOW = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;

    // ----------------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------------
    localparam int TX_CLK_SRC_BIT = 7;
    localparam int TX_SYNC_BIT = 4;
    localparam int TX_HIGH_SPEED_BIT = 2;
    localparam int TX_SHIFT_EMPTY_BIT = 1;
    localparam int RX_PORT_EN_BIT = 7;
    localparam int BAUD_RX_IDLE_BIT = 6;
    localparam int BAUD_WIDTH_BIT = 3;
    localparam logic [7:0] TX_CTL_RST = 8'h02;
    localparam logic [7:0] TX_CTL_WMASK = 8'hfd;
    localparam logic [7:0] RX_CTL_WMASK = 8'hf8;
    localparam logic [7:0] BAUD_CTL_WMASK = 8'hbb;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ----------------------------------------------------------------------
    // Divide factors, stored as factor minus one
    // ----------------------------------------------------------------------
    localparam logic [5:0] FACTOR64_M1 = 6'h3f;
    localparam logic [5:0] FACTOR16_M1 = 6'h0f;
    localparam logic [5:0] FACTOR4_M1 = 6'h03;

    typedef enum logic [1:0] {
        SBR_ASYNC = 2'b00,
        SBR_MASTER = 2'b01,
        SBR_SLAVE = 2'b10
    } sbr_mode_t;

endpackage

// *** core/sbr_timer.sv ***
// Purpose: Free-running tick timer with period divisor plus one.
// Assumes: Clear and run come from logic on the same clock.
// Notes: A pulse on tick marks every period+1 enabled cycles.
`timescale 1ns/1ps
module sbr_timer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clr,
    input wire logic run,
    input wire logic [15:0] period,
    output logic tick
);
    import sbr_pkg::*;

    logic [15:0] count_q;

    // ----------------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------------
    // Comparing with >= keeps the timer from running away if the period
    // shrinks below the current count.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= 16'h0000;
            tick <= 1'b0;
        end else if (ce) begin
            if (clr || !run) begin
                count_q <= 16'h0000;
                tick <= 1'b0;
            end else if (count_q >= period) begin
                count_q <= 16'h0000;
                tick <= 1'b1;
            end else begin
                count_q <= count_q + 16'h0001;
                tick <= 1'b0;
            end
        end
    end

endmodule

// *** core/sbr_vote.sv ***
// Purpose: Receive pin synchroniser and three-sample majority detector.
// Assumes: The pin is asynchronous to the clock.
// Notes: The third sample and the decision happen on the same strobe.
`timescale 1ns/1ps
module sbr_vote (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic pin,
    input wire logic samp,
    input wire logic last,
    output logic bit_out,
    output logic bit_valid
);
    import sbr_pkg::*;

    logic meta_q;
    logic sync_q;
    logic [1:0] hist_q;

    // ----------------------------------------------------------------------
    // Synchroniser
    // ----------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
        end else if (ce) begin
            meta_q <= pin;
            sync_q <= meta_q;
        end
    end

    // ----------------------------------------------------------------------
    // Majority vote
    // ----------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_q <= 2'b11;
            bit_out <= 1'b1;
            bit_valid <= 1'b0;
        end else if (ce) begin
            bit_valid <= last;
            if (samp) begin
                hist_q <= {hist_q[0], sync_q};
            end
            if (last) begin
                bit_out <= (hist_q[1] & hist_q[0]) | (hist_q[1] & sync_q)
                    | (hist_q[0] & sync_q);
            end
        end
    end

endmodule

// *** tb/sbr_top_props.sv ***
// Purpose: Port-level properties of the serial bit rate generator.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes: Bound to sbr_top from the testbench top file.
`timescale 1ns/1ps
module sbr_top_props (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic CK_O,
    input wire logic CK_OE,
    input wire logic BIT_TICK,
    input wire logic RX_BIT,
    input wire logic RX_BIT_VALID
);
    // ----------------------------------------------------------------------
    // Bus and output timing
    // ----------------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    chk_wait_answer: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST && CE
        |=> !AVS_WAITREQUEST) else $error("request not answered after one wait cycle");
    chk_wait_single: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
        else $error("waitrequest low longer than one cycle");
    chk_wait_idle: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST
        |=> AVS_WAITREQUEST) else $error("waitrequest dropped without a request");
    chk_rdata_upper: assert property (AVS_READDATA[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_rdata_hold: assert property (!(AVS_READ && AVS_WAITREQUEST) |=> $stable(AVS_READDATA))
        else $error("read data changed without a read");
    chk_tick_pulse: assert property (BIT_TICK |=> !BIT_TICK)
        else $error("bit tick longer than one cycle");
    chk_tick_space: assert property (CK_OE && BIT_TICK |=> !BIT_TICK [*3])
        else $error("master bit ticks closer than four cycles");
    chk_valid_pulse: assert property (RX_BIT_VALID |=> !RX_BIT_VALID)
        else $error("receive bit valid longer than one cycle");
    chk_clk_idle: assert property (!CK_OE |-> !CK_O)
        else $error("serial clock driven while not master");

    cov_write: cover property (AVS_WRITE && !AVS_WAITREQUEST);
    cov_read: cover property (AVS_READ && !AVS_WAITREQUEST);
    cov_master_tick: cover property (CK_OE && BIT_TICK);
    cov_rx_low: cover property (RX_BIT_VALID && !RX_BIT);
endmodule

// *** tb/tb_sbr_top.sv ***
// Purpose: Self-checking bench for the serial bit rate generator.
// Assumes: Avalon-MM slave answers after one wait cycle.
// Notes: Bit periods are measured in clock cycles between ticks.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_sbr_top;
    import sbr_pkg::*;
    logic clk, rst_n, ce, avs_read, avs_write, rxd, ck_i;
    logic avs_waitrequest, ck_o, ck_oe, bit_tick, rx_bit, rx_bit_valid;
    logic [ADDR_W-1:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata;
    logic [3:0] avs_byteenable;
    int err_count, tests_run, cycles, p, n;
    // Mode table: tx control, baud control, high, low, period, clock enable.
    logic [7:0] ctx[6] = '{8'h00, 8'h04, 8'h00, 8'h04, 8'h94, 8'h90};
    logic [7:0] cbd[6] = '{8'h00, 8'h00, 8'h08, 8'h08, 8'h00, 8'h08};
    logic [7:0] chi[6] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01};
    logic [7:0] clo[6] = '{8'h02, 8'h02, 8'h00, 8'h00, 8'h05, 8'h05};
    int cper[6] = '{192, 48, 4112, 1028, 24, 1048};
    logic coe[6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [ADDR_W-1:0] ra[7] = '{OFS_TX_CTL, OFS_RX_CTL, OFS_BAUD_CTL, OFS_DIV_HIGH,
        OFS_DIV_LOW, OFS_STATUS, 5'h18};
    logic [7:0] rv[7] = '{8'h02, 8'h00, 8'h40, 8'h00, 8'h00, 8'h01, 8'h00};

    sbr_top u_sbr_top (.CLK(clk), .RST_N(rst_n), .CE(ce), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_BYTEENABLE(avs_byteenable), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .RXD(rxd), .CK_I(ck_i), .CK_O(ck_o),
        .CK_OE(ck_oe), .BIT_TICK(bit_tick), .RX_BIT(rx_bit), .RX_BIT_VALID(rx_bit_valid));

    // ----------------------------------------------------------------------
    // Clock, timeout and verdict
    // ----------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("errors %0d checks %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // The longest mode runs about 12k cycles per pass; the ceiling leaves wide margin.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 80000) begin
            err_count++;
            $display("CHECK FAILED t=%0t timeout", $time);
            stop_test();
        end
    end

    // ----------------------------------------------------------------------
    // Bus and measurement tasks
    // ----------------------------------------------------------------------
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
            input logic [3:0] be = 4'h1);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        @(posedge clk);
    endtask

    task automatic chk_rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
        logic [31:0] q;
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        @(posedge clk);
        `CHK(q, {24'h000000, e})
    endtask

    task automatic cfg(input logic [7:0] tx, bd, hi, lo);
        wr(OFS_TX_CTL, tx);
        wr(OFS_BAUD_CTL, bd);
        wr(OFS_DIV_HIGH, hi);
        wr(OFS_DIV_LOW, lo);
    endtask

    task automatic to_tick(output int c);
        c = 0;
        do begin
            @(posedge clk);
            c++;
        end while (bit_tick !== 1'b1);
    endtask

    task automatic measure(output int c);
        to_tick(c);
        to_tick(c);
    endtask

    // One-cycle glitches against the level; the vote must keep the level.
    task automatic glitch(input logic lv);
        logic bad;
        int nv;
        bad = 1'b0;
        nv = 0;
        for (int k = 0; k < 128; k++) begin
            rxd <= (k % 16 == 5) ? ~lv : lv;
            @(posedge clk);
            nv += (rx_bit_valid === 1'b1) ? 1 : 0;
            if (k > 64 && rx_bit !== lv) begin
                bad = 1'b1;
            end
        end
        `CHK(bad, 1'b0)
        `CHK(nv, 8)
    endtask

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = '0;
        avs_writedata = '0;
        avs_byteenable = 4'h1;
        rxd = 1'b1;
        ck_i = 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        for (int i = 0; i < 7; i++) chk_rd(ra[i], rv[i]);
        wr(OFS_BAUD_CTL, 8'hff);
        chk_rd(OFS_BAUD_CTL, 8'hfb);
        wr(OFS_DIV_LOW, 8'h5a, 4'h0);
        chk_rd(OFS_DIV_LOW, 8'h00);
        wr(OFS_DIV_HIGH, 8'ha5);
        chk_rd(OFS_DIV_HIGH, 8'ha5);
        wr(5'h18, 8'hff);
        chk_rd(5'h18, 8'h00);
        wr(OFS_RX_CTL, 8'h80);
        chk_rd(OFS_RX_CTL, 8'h80);
        for (int i = 0; i < 6; i++) begin
            cfg(ctx[i], cbd[i], chi[i], clo[i]);
            measure(p);
            `CHK(p, cper[i])
            `CHK(ck_oe, coe[i])
            // In master modes the serial clock is high for exactly half of every bit period; in the other modes it stays low.
            n = 0;
            repeat (cper[i]) begin
                @(posedge clk);
                n += (ck_o === 1'b1) ? 1 : 0;
            end
            `CHK(n, coe[i] ? cper[i] / 2 : 0)
        end
        // A slow count is running; the new short divisor must not wait for it.
        cfg(8'h00, 8'h08, 8'h01, 8'hff);
        repeat (50) @(posedge clk);
        wr(OFS_DIV_HIGH, 8'h00);
        wr(OFS_DIV_LOW, 8'h01);
        to_tick(p);
        `CHK((p >= 24 && p <= 36), 1'b1)
        measure(p);
        `CHK(p, 32)
        // A stopped clock must stretch the bit period by the stopped cycles.
        ce <= 1'b0;
        repeat (10) @(posedge clk);
        ce <= 1'b1;
        to_tick(p);
        `CHK(p, 32)
        cfg(8'h04, 8'h00, 8'h00, 8'h00);
        glitch(1'b0);
        glitch(1'b1);
        cfg(8'h10, 8'h00, 8'h00, 8'h00);
        n = 0;
        for (int k = 0; k < 40; k++) begin
            @(posedge clk);
            n += (bit_tick === 1'b1) ? 1 : 0;
        end
        `CHK(n, 0)
        `CHK(ck_oe, 1'b0)
        ck_i <= 1'b1;
        to_tick(p);
        `CHK((p >= 2 && p <= 6), 1'b1)
        ck_i <= 1'b0;
        repeat (10) @(posedge clk);
        stop_test();
    end
endmodule

bind sbr_top sbr_top_props u_sbr_top_props (.CLK(CLK), .RST_N(RST_N), .CE(CE),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .CK_O(CK_O), .CK_OE(CK_OE), .BIT_TICK(BIT_TICK),
    .RX_BIT(RX_BIT), .RX_BIT_VALID(RX_BIT_VALID));
